/* rtl/prio_math_pkg.sv */
// What this block does
// - Math block starts on enable rising edge.
// - Always four operands and three operators.
// - Operators are add, subtract, multiply, divide.
// - Evaluate high, then medium, then low priority.
// - Final result rounds to nearest integer.
// - Divide by zero or overflow gives 32767; a final value at the positive datapath saturation limit gives -32768.
// - Negative overflow gives -32768; a final value at the negative datapath saturation limit gives 32767.
// - Enable low clears or holds the result.
// - Block operands clamp to the 16-bit range.
// - Operand is constant or another block's value.
// - Zero and overflow flags update each execution.
// - Detector starts on enable rising edge.
// - Detector selects zero, overflow or either flag.
// - Auto-clear resets output before each execution.
// - Without auto-clear the error output latches.
// - Clear input drives the error output low; an error detected in the same cycle still sets it.
// - Scan order decides same or next scan detection.
// - Null block reference keeps output low.
package prio_math_pkg;

    // Bus and datapath widths.
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int FIX_W = 48;
    localparam int FRAC_BITS = 8;
    localparam int BLOCK_NUM_W = 4;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_OPERATORS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_OPERAND0 = 8'h08;
    localparam logic [ADDR_W-1:0] OPERAND_STRIDE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DETECT_REF = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;

    // Result limits.
    localparam logic signed [15:0] RESULT_MAX = 16'sh7FFF;
    localparam logic signed [15:0] RESULT_MIN = 16'sh8000;

    typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_MUL, OP_DIV} op_sel_t;
    typedef enum logic [1:0] {PRIO_HIGH, PRIO_MED, PRIO_LOW} prio_t;
    typedef enum logic [1:0] {ERR_DIVZERO, ERR_OVERFLOW, ERR_EITHER} err_sel_t;

    // Control register layout, high bits first.
    typedef struct packed {
        logic mathFirst;
        err_sel_t errSel;
        logic autoClearSelect;
        logic holdWhenOff;
    } ctrl_cfg_t;

    // Operand register layout.
    typedef struct packed {
        logic [BLOCK_NUM_W-1:0] blockNum;
        logic fromBlock;
        logic signed [15:0] constVal;
    } operand_cfg_t;

    // APB request and answer, published signal names.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_t;

    // Values after reset.
    localparam ctrl_cfg_t CTRL_RESET = 5'h00;
    localparam logic [1:0] OPERATOR_RESET = 2'h0;
    localparam logic [1:0] PRIO1_RESET = 2'h0;
    localparam logic [1:0] PRIO2_RESET = 2'h1;
    localparam logic [1:0] PRIO3_RESET = 2'h2;
    localparam operand_cfg_t OPERAND_RESET = 21'h00_0000;
    localparam logic [7:0] DETECT_REF_RESET = 8'h00;

    // Evaluation takes one cycle per operator.
    localparam logic [1:0] LAST_STEP = 2'h2;

endpackage

/* rtl/math_op_unit.sv */
`timescale 1ns/10ps
// One fixed-point operation between two adjacent partial results.
module math_op_unit
    import prio_math_pkg::*;
#(
    parameter int W = FIX_W,
    parameter int FRAC = FRAC_BITS
)
(
    // Operands and operator.
    input wire logic signed [W-1:0] lhs,
    input wire logic signed [W-1:0] rhs,
    input wire op_sel_t opSel,
    // Result.
    output logic signed [W-1:0] res,
    output logic divZero
);

    localparam logic signed [2*W-1:0] SAT_HI = (2*W)'({1'b0, {(W-1){1'b1}}});
    localparam logic signed [2*W-1:0] SAT_LO = -SAT_HI;

    logic signed [2*W-1:0] wideL;
    logic signed [2*W-1:0] wideR;
    logic signed [2*W-1:0] wide;

    assign wideL = (2*W)'(lhs);
    assign wideR = (2*W)'(rhs);

    // Wide result first, then saturation; a final value left at a saturation limit
    // wraps in the top-level rounding and ends at the opposite 16-bit limit.
    // four operators
    always_comb
    begin
        divZero = 1'b0;
        case (opSel)
            OP_ADD: wide = wideL + wideR;
            OP_SUB: wide = wideL - wideR;
            OP_MUL: wide = (wideL * wideR) >>> FRAC;
            OP_DIV:
            begin
                if (rhs == '0)
                begin
                    divZero = 1'b1;
                    wide = SAT_HI;
                end
                else
                begin
                    wide = (wideL <<< FRAC) / wideR;
                end
            end
            default: wide = '0;
        endcase
        if (wide > SAT_HI)
            res = W'(SAT_HI);
        else if (wide < SAT_LO)
            res = W'(SAT_LO);
        else
            res = W'(wide);
    end

endmodule

/* rtl/prio_math_top.sv */
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
// Prioritised four-operand math block with its error detector, behind an APB slave.
module prio_math_top
    import prio_math_pkg::*;
#(
    parameter int NUM_BLOCKS = 8,
    parameter logic [7:0] MATH_BLOCK_NUM = 8'h01
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register bus.
    input wire apb_req_t apbReq,
    output apb_rsp_t apbRsp,
    // Scan sequencing and block inputs.
    input wire logic scanStrobe,
    input wire logic mathEnable,
    input wire logic detectEnable,
    input wire logic detectClear,
    input wire logic [NUM_BLOCKS-1:0][31:0] blockValues,
    // Results.
    output logic signed [15:0] resultValue,
    output logic divZeroFlag,
    output logic overflowFlag,
    output logic errorOut,
    output logic scanDone
);

    typedef enum logic [1:0] {S_IDLE, S_EVAL, S_FINISH} fsm_t;

    typedef struct packed {
        fsm_t fsm;
        logic [1:0] step;
        logic [2:0] joined;
        logic [3:0][FIX_W-1:0] val;
        logic zeroSeen;
        ctrl_cfg_t ctrl;
        logic [2:0][1:0] opSel;
        logic [2:0][1:0] prio;
        operand_cfg_t [3:0] opnd;
        logic [7:0] detRef;
        logic mathEnPrev;
        logic mathArmed;
        logic detEnPrev;
        logic detArmed;
        logic signed [15:0] result;
        logic divZero;
        logic overflow;
        logic errOut;
        logic done;
        apb_rsp_t rsp;
    } state_t;

    state_t s;
    state_t nxt;

    logic signed [15:0] opndVal [4];
    logic signed [FIX_W-1:0] opndFix [4];
    logic [1:0] idx;
    logic signed [FIX_W-1:0] unitL;
    logic signed [FIX_W-1:0] unitR;
    logic signed [FIX_W-1:0] unitY;
    logic unitZero;
    logic signed [FIX_W-1:0] fin;
    logic signed [FIX_W-1:0] mag;
    logic signed [FIX_W-1:0] rounded;
    logic [2:0] joinedNow;
    logic mathGo;
    logic detRun;
    logic selErr;
    logic useZero;
    logic useOvf;
    logic apbAccess;
    logic apbHit;
    logic [DATA_W-1:0] readVal;

    // Clamp an actual value from another block to the operand range.
    function automatic logic signed [15:0] clampOperand(input logic signed [31:0] v);
        if (v > 32'(RESULT_MAX))
            return RESULT_MAX;
        else if (v < 32'(RESULT_MIN))
            return RESULT_MIN;
        else
            return v[15:0];
    endfunction

    // True when position p shares a merged group with operator i under mask j.
    function automatic logic inGroup(input int p, input int i, input logic [2:0] j);
        logic ok;
        ok = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            if (p <= i && k >= p && k < i && !j[k])
                ok = 1'b0;
            if (p > i + 1 && k > i && k < p && !j[k])
                ok = 1'b0;
        end
        return ok;
    endfunction

    // Operand fetch: a constant or the clamped value of another block.
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_operand
            logic signed [31:0] picked;
            assign picked = (32'(s.opnd[g].blockNum) < NUM_BLOCKS)
                          ? $signed(blockValues[s.opnd[g].blockNum]) : 32'sh0000_0000;
            assign opndVal[g] = s.opnd[g].fromBlock ? clampOperand(picked)
                                                    : s.opnd[g].constVal;
            assign opndFix[g] = FIX_W'(opndVal[g]) <<< FRAC_BITS;
        end
    endgenerate

    // Pick the pending operator whose priority matches the current step. A
    // misconfigured priority set falls back to the leftmost pending operator,
    // so evaluation always finishes in three steps.
    // priority order
    always_comb
    begin
        idx = 2'h0;
        for (int k = 2; k >= 0; k--)
        begin
            if (!s.joined[k])
                idx = 2'(k);
        end
        for (int k = 2; k >= 0; k--)
        begin
            if (!s.joined[k] && s.prio[k] == s.step)
                idx = 2'(k);
        end
    end

    // Every member of a merged group holds the group value, so the operator
    // always reads its own left and right neighbours.
    assign unitL = $signed(s.val[idx]);
    assign unitR = $signed(s.val[idx + 2'h1]);
    assign joinedNow = s.joined | (3'h1 << idx);

    math_op_unit #(
        .W(FIX_W),
        .FRAC(FRAC_BITS)
    ) u_op (
        .lhs(unitL),
        .rhs(unitR),
        .opSel(op_sel_t'(s.opSel[idx])),
        .res(unitY),
        .divZero(unitZero)
    );

    // Round half away from zero on the fixed-point final value.
    // round to nearest
    always_comb
    begin
        fin = $signed(s.val[0]);
        mag = (fin < 0) ? -fin : fin;
        mag = (mag + FIX_W'(1 << (FRAC_BITS - 1))) >>> FRAC_BITS;
        rounded = (fin < 0) ? -mag : mag;
    end

    // APB decode of the register map.
    assign apbAccess = apbReq.psel && apbReq.penable;
    always_comb
    begin
        apbHit = 1'b0;
        readVal = '0;
        case (apbReq.paddr)
            OFS_CTRL:
            begin
                apbHit = 1'b1;
                readVal = DATA_W'(s.ctrl);
            end
            OFS_OPERATORS:
            begin
                apbHit = 1'b1;
                readVal = DATA_W'({2'h0, s.prio[2], s.prio[1], s.prio[0], 2'h0,
                                   s.opSel[2], s.opSel[1], s.opSel[0]});
            end
            OFS_DETECT_REF:
            begin
                apbHit = 1'b1;
                readVal = DATA_W'(s.detRef);
            end
            OFS_STATUS:
            begin
                apbHit = 1'b1;
                readVal = DATA_W'({s.mathArmed, s.errOut, s.overflow, s.divZero,
                                   s.result});
            end
            default:
            begin
                for (int k = 0; k < 4; k++)
                begin
                    if (apbReq.paddr == OFS_OPERAND0 + ADDR_W'(k) * OPERAND_STRIDE)
                    begin
                        apbHit = 1'b1;
                        readVal = DATA_W'({3'h0, s.opnd[k].blockNum, 3'h0,
                                           s.opnd[k].fromBlock, s.opnd[k].constVal});
                    end
                end
            end
        endcase
    end

    // Detector flags; the finish cycle derives fresh ones here, never from nxt, to avoid a loop.
    assign useZero = (s.fsm == S_FINISH) ? s.zeroSeen : s.divZero;
    assign useOvf = (s.fsm == S_FINISH) ? (!s.zeroSeen && (rounded > FIX_W'(RESULT_MAX)
                    || rounded < FIX_W'(RESULT_MIN))) : s.overflow;
    always_comb
    begin
        case (s.ctrl.errSel)
            ERR_DIVZERO: selErr = useZero;
            ERR_OVERFLOW: selErr = useOvf;
            ERR_EITHER: selErr = useZero | useOvf;
            default: selErr = 1'b0;
        endcase
    end

    // Next-state logic for the whole block.
    always_comb
    begin
        nxt = s;
        nxt.done = 1'b0;
        nxt.rsp.pready = 1'b0;
        nxt.rsp.pslverr = 1'b0;
        nxt.rsp.prdata = '0;
        mathGo = 1'b0;
        detRun = 1'b0;

        // Enable edges arm each block; dropping enable disarms it.
        // math rising edge
        nxt.mathEnPrev = mathEnable;
        nxt.mathArmed = mathEnable && (s.mathArmed || !s.mathEnPrev);
        nxt.detEnPrev = detectEnable;
        nxt.detArmed = detectEnable && (s.detArmed || !s.detEnPrev);

        // APB answers after one wait state; writes land on the completing edge.
        if (apbAccess && !s.rsp.pready)
        begin
            nxt.rsp.pready = 1'b1;
            nxt.rsp.pslverr = !apbHit;
            nxt.rsp.prdata = apbReq.pwrite ? '0 : readVal;
        end
        if (apbAccess && s.rsp.pready && apbReq.pwrite)
        begin
            case (apbReq.paddr)
                OFS_CTRL: nxt.ctrl = ctrl_cfg_t'(apbReq.pwdata[4:0]);
                OFS_OPERATORS:
                begin
                    for (int k = 0; k < 3; k++)
                    begin
                        nxt.opSel[k] = apbReq.pwdata[2*k +: 2];
                        nxt.prio[k] = apbReq.pwdata[8 + 2*k +: 2];
                    end
                end
                OFS_DETECT_REF: nxt.detRef = apbReq.pwdata[7:0];
                default:
                begin
                    for (int k = 0; k < 4; k++)
                    begin
                        if (apbReq.paddr == OFS_OPERAND0 + ADDR_W'(k) * OPERAND_STRIDE)
                        begin
                            nxt.opnd[k].constVal = apbReq.pwdata[15:0];
                            nxt.opnd[k].fromBlock = apbReq.pwdata[16];
                            nxt.opnd[k].blockNum = apbReq.pwdata[20 +: BLOCK_NUM_W];
                        end
                    end
                end
            endcase
        end

        // Math evaluation sequence, one pass per scan strobe.
        // once per scan
        case (s.fsm)
            S_IDLE:
            begin
                if (scanStrobe && nxt.mathArmed)
                begin
                    mathGo = 1'b1;
                    for (int k = 0; k < 4; k++)
                        nxt.val[k] = opndFix[k];
                    nxt.joined = 3'h0;
                    nxt.step = 2'h0;
                    nxt.zeroSeen = 1'b0;
                    nxt.fsm = S_EVAL;
                end
            end
            S_EVAL:
            begin
                for (int p = 0; p < 4; p++)
                begin
                    if (inGroup(p, int'(idx), joinedNow))
                        nxt.val[p] = unitY;
                end
                nxt.joined = joinedNow;
                nxt.zeroSeen = s.zeroSeen | unitZero;
                nxt.step = s.step + 2'h1;
                if (s.step == LAST_STEP)
                    nxt.fsm = S_FINISH;
            end
            S_FINISH:
            begin
                nxt.fsm = S_IDLE;
                nxt.done = 1'b1;
                nxt.divZero = s.zeroSeen;
                nxt.overflow = 1'b0;
                if (s.zeroSeen)
                begin
                    nxt.result = RESULT_MAX;
                end
                else if (rounded > FIX_W'(RESULT_MAX))
                begin
                    nxt.result = RESULT_MAX;
                    nxt.overflow = 1'b1;
                end
                else if (rounded < FIX_W'(RESULT_MIN))
                begin
                    nxt.result = RESULT_MIN;
                    nxt.overflow = 1'b1;
                end
                else
                begin
                    nxt.result = rounded[15:0];
                end
            end
            default: nxt.fsm = S_IDLE;
        endcase

        // With enable low the result is zeroed unless hold is chosen.
        // disable policy
        if (s.fsm == S_IDLE && !mathEnable && !s.ctrl.holdWhenOff)
            nxt.result = 16'sh0000;

        // Detector runs at the strobe when it comes first in the scan, or at the
        // end of the math pass when the math block comes first.
        // scan order
        if (s.ctrl.mathFirst)
            detRun = (s.fsm == S_FINISH) || (s.fsm == S_IDLE && scanStrobe && !mathGo);
        else
            detRun = s.fsm == S_IDLE && scanStrobe;

        // Clear is applied first so a same-cycle detection still sets the output.
        // clear input
        if (detectClear)
            nxt.errOut = 1'b0;
        if (detRun && nxt.detArmed)
        begin
            if (s.ctrl.autoClearSelect)
                nxt.errOut = selErr;
            else
                nxt.errOut = nxt.errOut | selErr;
        end
        if (s.detRef == 8'h00 || s.detRef != MATH_BLOCK_NUM)
            nxt.errOut = 1'b0;
    end

    // Single state register for the whole block.
    // registered outputs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.fsm <= S_IDLE;
            s.ctrl <= CTRL_RESET;
            for (int k = 0; k < 3; k++)
                s.opSel[k] <= OPERATOR_RESET;
            s.prio[0] <= PRIO1_RESET;
            s.prio[1] <= PRIO2_RESET;
            s.prio[2] <= PRIO3_RESET;
            for (int k = 0; k < 4; k++)
                s.opnd[k] <= OPERAND_RESET;
            s.detRef <= DETECT_REF_RESET;
            s.mathEnPrev <= 1'b1;
            s.detEnPrev <= 1'b1;
        end
        else
        begin
            s <= nxt;
        end
    end

    // Outputs straight from the state register.
    assign apbRsp = s.rsp;
    assign resultValue = s.result;
    assign divZeroFlag = s.divZero;
    assign overflowFlag = s.overflow;
    assign errorOut = s.errOut;
    assign scanDone = s.done;

endmodule

/* verification/prio_math_props.sv */
`timescale 1ns/10ps
// Watches the math block and its detector from the top-level ports only.
module prio_math_props
    import prio_math_pkg::*;
#(
    parameter int NUM_BLOCKS = 8
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register bus.
    input wire apb_req_t apbReq,
    input wire apb_rsp_t apbRsp,
    // Scan and block inputs.
    input wire logic scanStrobe,
    input wire logic mathEnable,
    input wire logic detectEnable,
    input wire logic detectClear,
    input wire logic [NUM_BLOCKS-1:0][31:0] blockValues,
    // Results.
    input wire logic signed [15:0] resultValue,
    input wire logic divZeroFlag,
    input wire logic overflowFlag,
    input wire logic errorOut,
    input wire logic scanDone
);
    // Everything lives in the one clock domain.
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // One wait state, then a single-cycle answer.
    apb_answer_a: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready
        |=> apbRsp.pready ##1 !apbRsp.pready) else $error("apb answer timing wrong");
    slv_error_a: assert property (apbRsp.pslverr |-> apbRsp.pready)
        else $error("slave error outside answer");
    done_pulse_a: assert property (scanDone |=> !scanDone)
        else $error("scan done longer than one cycle");
    // A finish needs an enabled strobe exactly five edges earlier; a fresh edge must run.
    done_cause_a: assert property (scanDone
        |-> $past(scanStrobe, 5) && $past(mathEnable, 5)) else $error("scan done without strobe");
    edge_start_a: assert property (scanStrobe && $rose(mathEnable) && $past(rst_n)
        |-> ##5 scanDone) else $error("enable edge did not start execution");
    flags_update_a: assert property ($changed({divZeroFlag, overflowFlag}) |-> scanDone)
        else $error("flags changed outside execution end");
    divzero_max_a: assert property (scanDone && divZeroFlag
        |-> resultValue == RESULT_MAX && !overflowFlag) else $error("divide by zero result");
    overflow_limit_a: assert property (scanDone && overflowFlag
        |-> resultValue == RESULT_MAX || resultValue == RESULT_MIN)
        else $error("overflow result not at a limit");
    err_rise_a: assert property ($rose(errorOut)
        |-> $past(detectEnable) && ($past(scanStrobe) || scanDone))
        else $error("error output rose without a detector run");
    // Sticky output only drops on clear, a run, or a register write.
    err_fall_a: assert property ($fell(errorOut) |-> $past(detectClear) || $past(scanStrobe)
        || scanDone || $past(apbRsp.pready) || $past(apbRsp.pready, 2))
        else $error("error output dropped without cause");
endmodule

bind prio_math_top prio_math_props #(.NUM_BLOCKS(NUM_BLOCKS)) i_props (.clk(clk),
    .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .scanStrobe(scanStrobe),
    .mathEnable(mathEnable), .detectEnable(detectEnable), .detectClear(detectClear),
    .blockValues(blockValues), .resultValue(resultValue), .divZeroFlag(divZeroFlag),
    .overflowFlag(overflowFlag), .errorOut(errorOut), .scanDone(scanDone));

/* verification/block_values_model.sv */
`timescale 1ns/10ps
// Stands in for the other blocks; each entry is that block's actual value.
module block_values_model
#(
    parameter int NUM_BLOCKS = 8
)
(
    // Actual values, index is the block number.
    output logic [NUM_BLOCKS-1:0][31:0] blockValues
);
    // Unset blocks read their own number, so a wrong index shows up.
    initial
    begin
        for (int i = 0; i < NUM_BLOCKS; i++)
            blockValues[i] = 32'(i);
    end

    // Values may lie far outside the operand range, as real blocks can.
    task automatic setValue(input int idx, input logic [31:0] val);
        blockValues[idx] <= val;
    endtask
endmodule

/* verification/tb_prioritized_math_with_error_flags.sv */
`timescale 1ns/10ps
// Self-checking bench: register map, worked equations, saturation, detector modes.
module tb_prioritized_math_with_error_flags
    import prio_math_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    apb_req_t apbReq = '0;
    apb_rsp_t apbRsp;
    logic scanStrobe = 1'b0;
    logic mathEnable = 1'b1;
    logic detectEnable = 1'b0;
    logic detectClear = 1'b0;
    logic [7:0][31:0] blockValues;
    logic signed [15:0] resultValue;
    logic divZeroFlag, overflowFlag, errorOut, scanDone, slvErr;
    logic [31:0] seed = 32'h0000_0045;
    logic [31:0] rd;
    logic [3:0][31:0] w;
    int errors = 0, n_checks = 0;
    // Corner table: equations, divide by zero, rounding, saturation, clamped block operands.
    int tv[10][4] = '{'{12, 6, 3, 1}, '{2, 3, 1, 4}, '{100, 25, 2, 1}, '{5, 0, 0, 0},
        '{7, 2, 0, 0}, '{-7, 2, 0, 0}, '{200, 200, 0, 0}, '{-200, 200, 0, 0}, '{0, 1, 0, 0},
        '{0, -1, 0, 0}};
    logic [13:0] to[10] = '{14'h211C, 14'h0608, 14'h180D, 14'h2403, 14'h2403, 14'h2403,
        14'h2402, 14'h2402, 14'h2401, 14'h2401};
    int te[10] = '{13, 17, 25, 32767, 4, -4, 32767, -32768, 32766, -32767};
    logic [1:0] tf[10] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0};
    logic [5:0] perm[6] = '{6'h24, 6'h18, 6'h21, 6'h09, 6'h12, 6'h06};

    prio_math_top #(.NUM_BLOCKS(8), .MATH_BLOCK_NUM(8'h01)) i_dut (.clk(clk), .rst_n(rst_n),
        .apbReq(apbReq), .apbRsp(apbRsp), .scanStrobe(scanStrobe), .mathEnable(mathEnable),
        .detectEnable(detectEnable), .detectClear(detectClear), .blockValues(blockValues),
        .resultValue(resultValue), .divZeroFlag(divZeroFlag), .overflowFlag(overflowFlag),
        .errorOut(errorOut), .scanDone(scanDone));
    block_values_model #(.NUM_BLOCKS(8)) i_blocks (.blockValues(blockValues));

    // Free-running 200 MHz clock.
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    function automatic int rnd(input int m);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return int'(seed % m);
    endfunction

    function automatic logic [31:0] cv(input int v);
        return {16'h0000, v[15:0]};
    endfunction

    // Unsaturated value in priority order; intermediates stay exact, as in the block.
    function automatic int model(input logic [13:0] c, input int a[4]);
        int v[$], op[$], pr[$];
        v = {a[0], a[1], a[2], a[3]};
        for (int i = 0; i < 3; i++)
        begin
            op.push_back(c[2*i+:2]);
            pr.push_back(c[8+2*i+:2]);
        end
        for (int p = 0; p < 3; p++)
            for (int i = 0; i < op.size(); i++)
                if (pr[i] == p)
                begin
                    v[i] = op[i] == 0 ? v[i] + v[i+1] : op[i] == 1 ? v[i] - v[i+1] : v[i] * v[i+1];
                    v.delete(i + 1);
                    op.delete(i);
                    pr.delete(i);
                    break;
                end
        return v[0];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits for pready with no limit, then idles an edge before the next.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do
            @(posedge clk);
        while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        slvErr = apbRsp.pslverr;
        apbReq <= '0;
        @(posedge clk);
    endtask

    // Loads one equation, fires a strobe with enable high and waits for the finish pulse.
    task automatic run(input logic [13:0] opw);
        int n;
        n = 0;
        apb(1'b1, OFS_OPERATORS, {18'h0_0000, opw});
        for (int i = 0; i < 4; i++)
            apb(1'b1, OFS_OPERAND0 + 8'(4 * i), w[i]);
        scanStrobe <= 1'b1;
        mathEnable <= 1'b1;
        @(posedge clk);
        scanStrobe <= 1'b0;
        do
            @(posedge clk);
        while (scanDone !== 1'b1 && ++n < 12);
        chk(n < 12, 1'b1);
    endtask

    task automatic tab(input int i);
        for (int j = 0; j < 4; j++)
            w[j] = cv(tv[i][j]);
        if (i > 7)
            w[0] = {8'h00, 4'(i - 5), 4'h1, 16'h0000};
        run(to[i]);
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog well beyond the under two thousand cycles the tests need.
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    // Main sequence.
    initial
    begin
        int a[4];
        int ex;
        logic [13:0] opw;
        repeat (3) @(posedge clk);
        i_blocks.setValue(3, 32'h0001_86A0);
        i_blocks.setValue(4, 32'hFFFE_7960);
        rst_n <= 1'b1;
        scanStrobe <= 1'b1;
        @(posedge clk);
        scanStrobe <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0000_0000);
            chk(rd, i == 1 ? 32'h0000_2400 : 32'h0000_0000);
            chk(slvErr, i == 8);
        end
        $display("reset and map test done");
        mathEnable <= 1'b0;
        @(posedge clk);
        mathEnable <= 1'b1;
        detectEnable <= 1'b1;
        apb(1'b1, OFS_DETECT_REF, 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_001A);
        for (int i = 0; i < 10; i++)
        begin
            tab(i);
            chk(resultValue, te[i]);
            chk({divZeroFlag, overflowFlag}, tf[i]);
            chk(errorOut, |tf[i]);
        end
        $display("corner table done");
        for (int i = 0; i < 40; i++)
        begin
            opw = {perm[rnd(6)], 2'b00, 2'(rnd(3)), 2'(rnd(3)), 2'(rnd(3))};
            for (int j = 0; j < 4; j++)
            begin
                a[j] = rnd(201) - 100;
                w[j] = cv(a[j]);
            end
            run(opw);
            ex = model(opw, a);
            chk(overflowFlag, ex > 32767 || ex < -32768);
            chk(resultValue, ex > 32767 ? 32767 : ex < -32768 ? -32768 : ex);
        end
        $display("random equations done");
        for (int e = 0; e < 2; e++)
        begin
            apb(1'b1, OFS_CTRL, 32'h0000_0012 | 32'(e << 2));
            tab(3);
            chk(errorOut, e == 0);
            tab(6);
            chk(errorOut, e == 1);
        end
        apb(1'b1, OFS_CTRL, 32'h0000_000A);
        tab(4);
        chk(errorOut, 1'b1);
        tab(4);
        chk(errorOut, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h0000_0018);
        tab(3);
        tab(4);
        chk(errorOut, 1'b1);
        detectClear <= 1'b1;
        @(posedge clk);
        detectClear <= 1'b0;
        @(posedge clk);
        chk(errorOut, 1'b0);
        apb(1'b1, OFS_DETECT_REF, 32'h0000_0000);
        tab(3);
        chk(errorOut, 1'b0);
        $display("detector test done");
        tab(0);
        mathEnable <= 1'b0;
        repeat (2) @(posedge clk);
        chk(resultValue, 0);
        tab(0);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        mathEnable <= 1'b0;
        repeat (2) @(posedge clk);
        chk(resultValue, 13);
        $display("disable policy test done");
        final_report();
    end
endmodule
